// [core/ipr_defs.svh]
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// register offsets on the plain register port
`define IPR_OFS_SIX       4'h0
`define IPR_OFS_SEVEN     4'h1
`define IPR_OFS_EIGHT     4'h2
`define IPR_OFS_NINE      4'h3

// register and field geometry
`define IPR_DATA_W        16
`define IPR_FLD_W         3
`define IPR_FLD_STRIDE    4
`define IPR_FLDS_PER_REG  4
`define IPR_NUM_REGS      4
`define IPR_NUM_SRC       16

// priority level encodings
`define IPR_LVL_OFF       3'h0
`define IPR_LVL_MIN       3'h1
`define IPR_LVL_RESET     3'h4
`define IPR_LVL_MAX       3'h7

// whole-register views
`define IPR_REG_RESET     16'h4444
`define IPR_IMPL_MASK     16'h7777
`define IPR_LEVELS_RESET  48'h924924924924

`endif

// [core/ipr_pkg.sv]
`include "ipr_defs.svh"

package ipr_pkg;

	typedef logic [`IPR_FLD_W-1:0] ipr_level_t;

	// register selected by the current address
	typedef enum logic [2:0] {
		IPR_SEL_SIX,
		IPR_SEL_SEVEN,
		IPR_SEL_EIGHT,
		IPR_SEL_NINE,
		IPR_SEL_NONE
	} ipr_sel_t;

	typedef struct packed {
		ipr_level_t level;
	} ipr_field_st_t;

	typedef struct packed {
		logic irq;
	} ipr_gate_st_t;

	typedef struct packed {
		logic [`IPR_DATA_W-1:0] rdata;
		logic                   seen_wr;
	} ipr_top_st_t;

endpackage

// [core/ipr_field_if.sv]
// one priority field: write port towards the store, level towards its users
interface ipr_field_if;
	logic                wr;
	ipr_pkg::ipr_level_t wdata;
	ipr_pkg::ipr_level_t level;

	modport owner (
		input  wr,
		input  wdata,
		output level
	);

	modport reader (
		input  level
	);
endinterface

// [core/ipr_field.sv]
`include "ipr_defs.svh"

module ipr_field (
	input  wire logic    sys_clk_i,
	input  wire logic    reset_n_i,
	ipr_field_if.owner   fld
);

	ipr_pkg::ipr_field_st_t st_q;
	ipr_pkg::ipr_field_st_t st_d;

	// a write replaces the whole field, nothing else touches it
	always_comb begin
		st_d = st_q;
		if (fld.wr) begin
			st_d.level = fld.wdata;
		end
	end

	// every source wakes up at the middle level
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '{level: `IPR_LVL_RESET};
		end else begin
			st_q <= st_d;
		end
	end

	assign fld.level = st_q.level;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	field_write_a: assert property (fld.wr |=> fld.level == $past(fld.wdata))
		else $error("field did not take written value");
	field_hold_a: assert property (!fld.wr |=> $stable(fld.level))
		else $error("field changed without a write");

endmodule

// [core/ipr_gate.sv]
`include "ipr_defs.svh"

module ipr_gate (
	input  wire logic    sys_clk_i,
	input  wire logic    reset_n_i,
	input  wire logic    src_req_i,
	ipr_field_if.reader  fld,
	output logic         irq_o
);

	ipr_pkg::ipr_gate_st_t st_q;
	ipr_pkg::ipr_gate_st_t st_d;

	// level zero masks the source; any other level lets it through
	always_comb begin
		st_d     = st_q;
		st_d.irq = src_req_i && (fld.level != `IPR_LVL_OFF);
	end

	// registered so the request output is glitch free
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '{irq: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign irq_o = st_q.irq;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	off_blocks_a: assert property (fld.level == `IPR_LVL_OFF |=> !irq_o)
		else $error("disabled source raised a request");
	min_raises_a: assert property (src_req_i && fld.level == `IPR_LVL_MIN |=> irq_o)
		else $error("level one source not raised");
	enabled_raises_a: assert property (src_req_i && fld.level != `IPR_LVL_OFF |=> irq_o)
		else $error("enabled source not raised");
	no_req_quiet_a: assert property (!src_req_i |=> !irq_o)
		else $error("request raised without source");

endmodule

// [core/ipr_regs.sv]
// Decided for this implementation: the register addresses and strobed register access.
`include "ipr_defs.svh"

module ipr_regs #(
	parameter int ADDR_W = 4
) (
	input  wire logic                                  sys_clk_i,
	input  wire logic                                  reset_n_i,
	input  wire logic [ADDR_W-1:0]                     addr_i,
	input  wire logic [`IPR_DATA_W-1:0]                wdata_i,
	input  wire logic                                  wr_i,
	input  wire logic                                  rd_i,
	input  wire logic [`IPR_NUM_SRC-1:0]               src_req_i,
	output logic      [`IPR_DATA_W-1:0]                rdata_o,
	output logic      [`IPR_NUM_SRC*`IPR_FLD_W-1:0]    levels_o,
	output logic      [`IPR_NUM_SRC-1:0]               irq_o
);

	// offsets must be reachable on the address port
	if (ADDR_W < 2) begin : g_chk_addr
		$error("ADDR_W too small for four registers");
	end

	// field geometry must tile the data word exactly, gaps included
	if (`IPR_FLD_STRIDE * `IPR_FLDS_PER_REG != `IPR_DATA_W) begin : g_chk_stride
		$error("field stride does not tile the data word");
	end

	// one gap bit per field is what keeps bits 15, 11, 7 and 3 unimplemented
	if (`IPR_FLD_W + 1 != `IPR_FLD_STRIDE) begin : g_chk_gap
		$error("each field needs exactly one gap bit above it");
	end

	// one field per source, no spare or missing slots
	if (`IPR_NUM_REGS * `IPR_FLDS_PER_REG != `IPR_NUM_SRC) begin : g_chk_src
		$error("source count does not match register fields");
	end

	ipr_pkg::ipr_top_st_t       st_q;
	ipr_pkg::ipr_top_st_t       st_d;
	ipr_pkg::ipr_sel_t          sel;
	logic [`IPR_NUM_REGS-1:0]   wr_hit;
	logic [`IPR_DATA_W-1:0]     word_six;
	logic [`IPR_DATA_W-1:0]     word_seven;
	logic [`IPR_DATA_W-1:0]     word_eight;
	logic [`IPR_DATA_W-1:0]     word_nine;
	logic [`IPR_DATA_W-1:0]     cur_word;

	ipr_pkg::ipr_level_t        dma_two_done_level;
	ipr_pkg::ipr_level_t        compare_three_level;
	ipr_pkg::ipr_level_t        compare_four_level;
	ipr_pkg::ipr_level_t        timer_four_level;
	ipr_pkg::ipr_level_t        timer_five_level;
	ipr_pkg::ipr_level_t        ext_irq_two_level;
	ipr_pkg::ipr_level_t        serial_two_rx_level;
	ipr_pkg::ipr_level_t        serial_two_tx_level;
	ipr_pkg::ipr_level_t        spi_two_error_level;
	ipr_pkg::ipr_level_t        spi_two_event_level;
	ipr_pkg::ipr_level_t        can_one_rx_level;
	ipr_pkg::ipr_level_t        can_one_event_level;
	ipr_pkg::ipr_level_t        dma_three_done_level;
	ipr_pkg::ipr_level_t        capture_three_level;
	ipr_pkg::ipr_level_t        capture_four_level;
	ipr_pkg::ipr_level_t        capture_five_level;

	// address decode; anything outside the four words selects none
	// so a stray probe of an unmapped offset reads zero and writes nothing
	function automatic ipr_pkg::ipr_sel_t decode(input logic [ADDR_W-1:0] a);
		ipr_pkg::ipr_sel_t s;
		s = ipr_pkg::IPR_SEL_NONE;
		if (a == ADDR_W'(`IPR_OFS_SIX)) begin
			s = ipr_pkg::IPR_SEL_SIX;
		end else if (a == ADDR_W'(`IPR_OFS_SEVEN)) begin
			s = ipr_pkg::IPR_SEL_SEVEN;
		end else if (a == ADDR_W'(`IPR_OFS_EIGHT)) begin
			s = ipr_pkg::IPR_SEL_EIGHT;
		end else if (a == ADDR_W'(`IPR_OFS_NINE)) begin
			s = ipr_pkg::IPR_SEL_NINE;
		end
		return s;
	endfunction

	assign sel = decode(addr_i);

	// one write strobe per register; unmapped writes hit nothing
	assign wr_hit[0] = wr_i && (sel == ipr_pkg::IPR_SEL_SIX);
	assign wr_hit[1] = wr_i && (sel == ipr_pkg::IPR_SEL_SEVEN);
	assign wr_hit[2] = wr_i && (sel == ipr_pkg::IPR_SEL_EIGHT);
	assign wr_hit[3] = wr_i && (sel == ipr_pkg::IPR_SEL_NINE);

	ipr_field_if fif [`IPR_NUM_SRC] ();

	// source k lives in register k/4, field k%4 counted from bit 0
	for (genvar k = 0; k < `IPR_NUM_SRC; k++) begin : g_src
		// only the three field bits are passed on, so the gap bits are dropped
		assign fif[k].wr    = wr_hit[k / `IPR_FLDS_PER_REG];
		assign fif[k].wdata = wdata_i[(k % `IPR_FLDS_PER_REG) * `IPR_FLD_STRIDE +: `IPR_FLD_W];

		ipr_field u_field (
			.sys_clk_i (sys_clk_i),
			.reset_n_i (reset_n_i),
			.fld       (fif[k])
		);

		ipr_gate u_gate (
			.sys_clk_i (sys_clk_i),
			.reset_n_i (reset_n_i),
			.src_req_i (src_req_i[k]),
			.fld       (fif[k]),
			.irq_o     (irq_o[k])
		);

		// level outputs come straight from the field flops
		assign levels_o[k * `IPR_FLD_W +: `IPR_FLD_W] = fif[k].level;
	end

	// register six sources
	assign dma_two_done_level   = fif[0].level;
	assign compare_three_level  = fif[1].level;
	assign compare_four_level   = fif[2].level;
	assign timer_four_level     = fif[3].level;

	// register seven sources
	assign timer_five_level     = fif[4].level;
	assign ext_irq_two_level    = fif[5].level;
	assign serial_two_rx_level  = fif[6].level;
	assign serial_two_tx_level  = fif[7].level;

	// register eight sources
	assign spi_two_error_level  = fif[8].level;
	assign spi_two_event_level  = fif[9].level;
	assign can_one_rx_level     = fif[10].level;
	assign can_one_event_level  = fif[11].level;

	// register nine sources
	assign dma_three_done_level = fif[12].level;
	assign capture_three_level  = fif[13].level;
	assign capture_four_level   = fif[14].level;
	assign capture_five_level   = fif[15].level;

	// read views; the gap bits are hard zeros, not storage
	assign word_six = {
		1'b0, timer_four_level,
		1'b0, compare_four_level,
		1'b0, compare_three_level,
		1'b0, dma_two_done_level
	};

	assign word_seven = {
		1'b0, serial_two_tx_level,
		1'b0, serial_two_rx_level,
		1'b0, ext_irq_two_level,
		1'b0, timer_five_level
	};

	assign word_eight = {
		1'b0, can_one_event_level,
		1'b0, can_one_rx_level,
		1'b0, spi_two_event_level,
		1'b0, spi_two_error_level
	};

	assign word_nine = {
		1'b0, capture_five_level,
		1'b0, capture_four_level,
		1'b0, capture_three_level,
		1'b0, dma_three_done_level
	};

	// word picked by the current address
	always_comb begin
		case (sel)
			ipr_pkg::IPR_SEL_SIX: begin
				cur_word = word_six;
			end
			ipr_pkg::IPR_SEL_SEVEN: begin
				cur_word = word_seven;
			end
			ipr_pkg::IPR_SEL_EIGHT: begin
				cur_word = word_eight;
			end
			ipr_pkg::IPR_SEL_NINE: begin
				cur_word = word_nine;
			end
			default: begin
				cur_word = '0;
			end
		endcase
	end

	// read data is valid only in the cycle after the strobe, zero otherwise,
	// so a stale value can never be mistaken for a fresh read
	always_comb begin
		st_d       = st_q;
		st_d.rdata = '0;
		if (rd_i) begin
			st_d.rdata = cur_word;
		end
		// sticky marker for the reset-value check; costs one flop
		if (wr_i) begin
			st_d.seen_wr = 1'b1;
		end
	end

	// register the read port
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '{rdata: '0, seen_wr: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o = st_q.rdata;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	// reset value holds until software writes
	reset_levels_a: assert property (!st_q.seen_wr |-> levels_o == `IPR_LEVELS_RESET)
		else $error("levels not at reset value before first write");

	// each write lands in its own word, gap bits dropped
	write_six_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_SIX |=> word_six == ($past(wdata_i) & `IPR_IMPL_MASK)
	)
		else $error("register six write mismatch");

	write_seven_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_SEVEN |=> word_seven == ($past(wdata_i) & `IPR_IMPL_MASK)
	)
		else $error("register seven write mismatch");

	write_eight_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_EIGHT |=> word_eight == ($past(wdata_i) & `IPR_IMPL_MASK)
	)
		else $error("register eight write mismatch");

	write_nine_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_NINE |=> word_nine == ($past(wdata_i) & `IPR_IMPL_MASK)
	)
		else $error("register nine write mismatch");

	// a write to one register leaves the other twelve levels alone
	isolate_six_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_SIX |=> $stable(levels_o[47:12])
	)
		else $error("register six write touched another register");

	isolate_seven_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_SEVEN |=> $stable(levels_o[47:24]) && $stable(levels_o[11:0])
	)
		else $error("register seven write touched another register");

	isolate_eight_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_EIGHT |=> $stable(levels_o[47:36]) && $stable(levels_o[23:0])
	)
		else $error("register eight write touched another register");

	isolate_nine_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_NINE |=> $stable(levels_o[35:0])
	)
		else $error("register nine write touched another register");

	// register views and the level bus are built on separate paths; they must agree
	view_six_a: assert property (
		levels_o[11:0] == {word_six[14:12], word_six[10:8], word_six[6:4], word_six[2:0]}
	)
		else $error("register six view and level bus disagree");
	view_seven_a: assert property (
		levels_o[23:12] == {word_seven[14:12], word_seven[10:8], word_seven[6:4], word_seven[2:0]}
	)
		else $error("register seven view and level bus disagree");
	view_eight_a: assert property (
		levels_o[35:24] == {word_eight[14:12], word_eight[10:8], word_eight[6:4], word_eight[2:0]}
	)
		else $error("register eight view and level bus disagree");
	view_nine_a: assert property (
		levels_o[47:36] == {word_nine[14:12], word_nine[10:8], word_nine[6:4], word_nine[2:0]}
	)
		else $error("register nine view and level bus disagree");

	read_back_a: assert property (rd_i |=> rdata_o == $past(cur_word))
		else $error("read data differs from register");

	// each mapped read returns its own word, not a neighbour's
	read_six_a: assert property (rd_i && sel == ipr_pkg::IPR_SEL_SIX |=> rdata_o == $past(word_six))
		else $error("register six read returned another word");
	read_seven_a: assert property (rd_i && sel == ipr_pkg::IPR_SEL_SEVEN |=> rdata_o == $past(word_seven))
		else $error("register seven read returned another word");
	read_eight_a: assert property (rd_i && sel == ipr_pkg::IPR_SEL_EIGHT |=> rdata_o == $past(word_eight))
		else $error("register eight read returned another word");
	read_nine_a: assert property (rd_i && sel == ipr_pkg::IPR_SEL_NINE |=> rdata_o == $past(word_nine))
		else $error("register nine read returned another word");
	read_quiet_a: assert property (rd_i |=> $stable(levels_o))
		else $error("a read changed a level");

	reserved_zero_a: assert property ((rdata_o & ~`IPR_IMPL_MASK) == '0)
		else $error("reserved bit read as one");

	idle_rdata_a: assert property (!rd_i || sel == ipr_pkg::IPR_SEL_NONE |=> rdata_o == '0)
		else $error("read data not zero outside a mapped read");

	unmapped_write_a: assert property (wr_i && sel == ipr_pkg::IPR_SEL_NONE |=> $stable(levels_o))
		else $error("unmapped write changed a level");

	write_then_read_a: assert property (
		wr_i && sel == ipr_pkg::IPR_SEL_SIX ##1 rd_i && sel == ipr_pkg::IPR_SEL_SIX
		|=> rdata_o == ($past(wdata_i, 2) & `IPR_IMPL_MASK)
	)
		else $error("back to back read missed the write");

	disabled_timer_a: assert property (
		timer_four_level == `IPR_LVL_OFF ##1 timer_four_level == `IPR_LVL_OFF |-> !irq_o[3]
	)
		else $error("disabled timer request seen");

	// every source, not only the one watched by name: a zero level masks its request
	for (genvar k = 0; k < `IPR_NUM_SRC; k++) begin : g_src_chk
		src_masked_a: assert property (
			@(posedge sys_clk_i) disable iff (!reset_n_i)
			levels_o[k * `IPR_FLD_W +: `IPR_FLD_W] == `IPR_LVL_OFF |=> !irq_o[k]
		)
			else $error("masked source request reached the output");
		src_passed_a: assert property (
			@(posedge sys_clk_i) disable iff (!reset_n_i)
			src_req_i[k] && levels_o[k * `IPR_FLD_W +: `IPR_FLD_W] != `IPR_LVL_OFF |=> irq_o[k]
		)
			else $error("enabled source request did not reach the output");
	end

	// main scenarios the bench is meant to reach
	wr_rd_cov_c: cover property (wr_i ##1 rd_i);
	top_level_c: cover property (irq_o[3] && timer_four_level == `IPR_LVL_MAX);
	masked_req_c: cover property (src_req_i[0] && dma_two_done_level == `IPR_LVL_OFF);
	read_nine_c: cover property (rd_i && sel == ipr_pkg::IPR_SEL_NINE);
	unmapped_wr_c: cover property (wr_i && sel == ipr_pkg::IPR_SEL_NONE);

endmodule

// [bench/ipr_regs_tb.sv]
module interrupt_priority_regs_6_to_9_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
	} ipr_row_t;

	logic        sys_clk_i;
	logic        reset_n_i;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [15:0] src_req_i;
	logic [15:0] rdata_o;
	logic [47:0] levels_o;
	logic [15:0] irq_o;
	int          err_total;
	int          samples_checked;
	logic [15:0] model [4];
	ipr_row_t    rows [6];
	logic [15:0] rd_val;

	ipr_regs #(
		.ADDR_W(4)
	) uut (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.addr_i   (addr_i),
		.wdata_i  (wdata_i),
		.wr_i     (wr_i),
		.rd_i     (rd_i),
		.src_req_i(src_req_i),
		.rdata_o  (rdata_o),
		.levels_o (levels_o),
		.irq_o    (irq_o)
	);

	// 100 MHz system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// expected level bus, source 4r+f from field f of register r
	function automatic logic [47:0] exp_levels();
		logic [47:0] v;
		v = '0;
		for (int r = 0; r < 4; r++)
			for (int f = 0; f < 4; f++)
				v[(4*r+f)*3 +: 3] = model[r][4*f +: 3];
		return v;
	endfunction

	// a zero level blocks the request, any other level lets it through
	function automatic logic [15:0] exp_irq(input logic [15:0] src);
		logic [15:0] e;
		for (int k = 0; k < 16; k++)
			e[k] = src[k] && (model[k/4][4*(k%4) +: 3] != 3'h0);
		return e;
	endfunction

	task automatic print_verdict();
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk48(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: levels got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_irq(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: irq got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe; caller sits just after an edge
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	// reset held 6 cycles, then every field is back at level 4
	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		for (int r = 0; r < 4; r++) model[r] = 16'h4444;
		chk48(levels_o, 48'h924924924924);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		for (int r = 0; r < 4; r++) begin
			rd_reg(r[3:0], rd_val);
			chk16(rd_val, 16'h4444);
		end
	endtask

	// hang guard, far beyond the fifty or so cycles the run needs
	initial begin
		#20000;
		err_total++;
		print_verdict();
	end

	// main sequence
	initial begin
		err_total       = 0;
		samples_checked = 0;
		reset_n_i       = 1'b0;
		addr_i          = 4'h0;
		wdata_i         = 16'h0000;
		wr_i            = 1'b0;
		rd_i            = 1'b0;
		src_req_i       = 16'h0000;
		rows[0] = '{4'h0, 16'hffff, 16'h7777};
		rows[1] = '{4'h1, 16'h8888, 16'h0000};
		rows[2] = '{4'h2, 16'h1234, 16'h1234};
		rows[3] = '{4'h3, 16'hfedc, 16'h7654};
		rows[4] = '{4'h0, 16'h1357, 16'h1357};
		rows[5] = '{4'h1, 16'h2461, 16'h2461};
		do_reset();
		// write then read back at once, placement seen on the level bus
		foreach (rows[i]) begin
			wr_reg(rows[i].addr, rows[i].wdata);
			model[rows[i].addr[1:0]] = rows[i].exp;
			chk48(levels_o, exp_levels());
			rd_reg(rows[i].addr, rd_val);
			chk16(rd_val, rows[i].exp);
		end
		// read data drops to zero after its single cycle
		@(posedge sys_clk_i);
		#1;
		chk16(rdata_o, 16'h0000);
		// unmapped address: write ignored, read gives zero
		wr_reg(4'h4, 16'h0000);
		chk48(levels_o, exp_levels());
		rd_reg(4'hf, rd_val);
		chk16(rd_val, 16'h0000);
		// top and lowest levels pass, zero level blocks
		wr_reg(4'h0, 16'h7770);
		model[0] = 16'h7770;
		wr_reg(4'h1, 16'h0100);
		model[1] = 16'h0100;
		src_req_i <= 16'hffff;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk_irq(irq_o, exp_irq(16'hffff));
		// timer four drops from the top level to off
		wr_reg(4'h1, 16'h0000);
		model[1] = 16'h0000;
		wr_reg(4'h0, 16'h0777);
		model[0] = 16'h0777;
		@(posedge sys_clk_i);
		#1;
		chk_irq(irq_o, exp_irq(16'hffff));
		src_req_i <= 16'h0000;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk_irq(irq_o, 16'h0000);
		// second reset in mid-run restores level 4 everywhere
		do_reset();
		print_verdict();
	end
endmodule
